/* File: logic/counter_array_pkg.sv */
/*
  Constants for the counter array control and status register.
  Assumes an SFR bus with byte and bit access, synchronous to the core clock.
*/
`default_nettype none

package counter_array_pkg;
  // ----------------------------------------
  // Address map
  // ----------------------------------------
  localparam logic [7:0] CTRL_ADDR      = 8'hD8;
  localparam logic [7:0] CTRL_RESET     = 8'h00;
  localparam logic [4:0] BIT_BASE_MASK  = 5'h1F;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam logic [2:0] POS_OVERFLOW   = 3'h7;
  localparam logic [2:0] POS_RUN        = 3'h6;
  localparam logic [2:0] POS_UNUSED     = 3'h5;
  localparam logic [2:0] POS_MODULE4    = 3'h4;
  localparam int         NUM_MODULES    = 5;
  localparam int         NUM_FLAGS      = 6;
  localparam int         FLAG_OVERFLOW  = 5;

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  localparam logic [15:0] COUNT_ALL_ONES = 16'hFFFF;
endpackage

`default_nettype wire

/* File: logic/flag_if.sv */
/*
  Carrier between the register decode and the sticky flag bank.
  Assumes both ends share one clock.
*/
`timescale 1ns/1ns
`default_nettype none

interface flag_if;
  logic [5:0] hw_set;
  logic [5:0] sw_wr;
  logic [5:0] sw_val;
  logic [5:0] flags;

  modport ctrl (output hw_set, output sw_wr, output sw_val, input flags);
  modport bank (input hw_set, input sw_wr, input sw_val, output flags);
endinterface

`default_nettype wire

/* File: logic/flag_bank.sv */
/*
  Sticky flag bank: overflow flag and five module match flags.
  Assumes set and write strobes are single-cycle and qualified by the caller.
*/
`timescale 1ns/1ns
`default_nettype none

module flag_bank (
  // Clock and reset
  input  wire logic core_clk_in,
  input  wire logic rst_in,
  input  wire logic ce_in,
  // Flag access
  flag_if.bank      fl
);

  // ----------------------------------------
  // Next value
  // ----------------------------------------
  logic [5:0] flags;
  wire  [5:0] next_flags;

  assign next_flags = (flags & ~fl.sw_wr) | (fl.sw_wr & fl.sw_val) | fl.hw_set;
  assign fl.flags   = flags;

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      flags <= 6'h00;
    end else if (ce_in) begin
      flags <= next_flags;
    end
  end

endmodule // flag_bank

`default_nettype wire

/* File: logic/counter_array_ctrl.sv */
/*
  Control and status register of the counter array: run bit, overflow
  flag, five module match flags, interrupt request and watchdog forcing.
  Assumes the counter, the modules and the mode register sit outside and
  that all inputs are synchronous to core_clk_in.
*/
// How it works
// - Counter wrap from all-ones sets overflow
// - Enabled overflow flag raises interrupt request
// - Flags sticky; software writes zero clears
// - Run bit advances or stops counter
// - Bit five reads zero, ignores writes
// - Module match or capture sets flag
// - Enabled module flag raises interrupt request
// - Register at 0xD8, bit-addressable
// - Watchdog on: one to module4 flag resets
// - Watchdog on: counter runs, run bit stored
// - Mode-register enable gates overflow interrupt
`timescale 1ns/1ns
`default_nettype none

module counter_array_ctrl (
  // Clock, reset, enable
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  input  wire logic        ce_in,
  // SFR byte access
  input  wire logic [7:0]  sfr_addr_in,
  input  wire logic        sfr_wr_in,
  input  wire logic        sfr_rd_in,
  input  wire logic [7:0]  sfr_wdata_in,
  output logic      [7:0]  sfr_rdata_out,
  output logic             sfr_rvalid_out,
  // SFR bit access
  input  wire logic [7:0]  bit_addr_in,
  input  wire logic        bit_wr_in,
  input  wire logic        bit_rd_in,
  input  wire logic        bit_wdata_in,
  output logic             bit_rdata_out,
  output logic             bit_rvalid_out,
  // Counter
  input  wire logic [15:0] counter_value_in,
  input  wire logic        counter_tick_in,
  output logic             counter_run_out,
  // Modules and mode register
  input  wire logic [4:0]  module_event_in,
  input  wire logic [4:0]  module_irq_enable_in,
  input  wire logic        overflow_irq_enable_in,
  input  wire logic        watchdog_enable_in,
  // Requests
  output logic             irq_out,
  output logic             watchdog_reset_out
);

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic logic [7:0] write_mask(input logic       byte_hit,
                                            input logic       bit_hit,
                                            input logic [2:0] idx);
    logic [7:0] m;
    m = 8'h00;
    if (byte_hit) begin
      m = 8'hFF;
    end else if (bit_hit) begin
      m[idx] = 1'b1;
    end
    return m;
  endfunction

  function automatic logic [5:0] flag_bits(input logic [7:0] v);
    return {v[counter_array_pkg::POS_OVERFLOW], v[counter_array_pkg::POS_MODULE4:0]};
  endfunction

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  logic       run;
  flag_if     fl ();

  wire        byte_hit;
  wire        byte_rd_hit;
  wire        bit_in_reg;
  wire        bit_wr_hit;
  wire        bit_rd_hit;
  wire [2:0]  bit_idx;
  wire [7:0]  wr_mask;
  wire [7:0]  wr_val;
  wire [7:0]  reg_value;
  wire        overflow_event;
  wire        wd_force;
  wire        next_run;

  assign byte_hit    = sfr_wr_in && (sfr_addr_in == counter_array_pkg::CTRL_ADDR);
  assign byte_rd_hit = sfr_rd_in && (sfr_addr_in == counter_array_pkg::CTRL_ADDR);
  assign bit_in_reg  = (bit_addr_in[7:3] == counter_array_pkg::CTRL_ADDR[7:3]);
  assign bit_wr_hit  = bit_wr_in && bit_in_reg;
  assign bit_rd_hit  = bit_rd_in && bit_in_reg;
  assign bit_idx     = bit_addr_in[2:0];
  assign wr_mask     = write_mask(byte_hit, bit_wr_hit, bit_idx);
  assign wr_val      = byte_hit ? sfr_wdata_in : {8{bit_wdata_in}};

  assign reg_value = {fl.flags[counter_array_pkg::FLAG_OVERFLOW], run, 1'b0,
                      fl.flags[counter_array_pkg::NUM_MODULES-1:0]};

  // ----------------------------------------
  // Flag events
  // ----------------------------------------
  // Wrap detection
  assign overflow_event = counter_tick_in && counter_run_out &&
                          (counter_value_in == counter_array_pkg::COUNT_ALL_ONES);

  assign fl.hw_set = {overflow_event, module_event_in};
  assign fl.sw_wr  = flag_bits(wr_mask);
  assign fl.sw_val = flag_bits(wr_val);

  flag_bank u_flags (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .ce_in       (ce_in),
    .fl          (fl.bank)
  );

  // ----------------------------------------
  // Run control
  // ----------------------------------------
  // Run bit write
  assign next_run = wr_mask[counter_array_pkg::POS_RUN] ?
                    wr_val[counter_array_pkg::POS_RUN] : run;
  assign counter_run_out = run || watchdog_enable_in;

  assign wd_force = watchdog_enable_in && wr_mask[counter_array_pkg::POS_MODULE4] &&
                    wr_val[counter_array_pkg::POS_MODULE4];

  // ----------------------------------------
  // Interrupt request
  // ----------------------------------------
  // Overflow and module match request
  assign irq_out = (fl.flags[counter_array_pkg::FLAG_OVERFLOW] && overflow_irq_enable_in) ||
                   (|(fl.flags[counter_array_pkg::NUM_MODULES-1:0] & module_irq_enable_in));

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      run                <= counter_array_pkg::CTRL_RESET[counter_array_pkg::POS_RUN];
      watchdog_reset_out <= 1'b0;
    end else if (ce_in) begin
      run                <= next_run;
      watchdog_reset_out <= wd_force;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sfr_rdata_out  <= 8'h00;
      sfr_rvalid_out <= 1'b0;
      bit_rdata_out  <= 1'b0;
      bit_rvalid_out <= 1'b0;
    end else if (ce_in) begin
      sfr_rdata_out  <= byte_rd_hit ? reg_value : 8'h00;
      sfr_rvalid_out <= byte_rd_hit;
      bit_rdata_out  <= bit_rd_hit && reg_value[bit_idx];
      bit_rvalid_out <= bit_rd_hit;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_overflow_set: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    ce_in && overflow_event |=> fl.flags[counter_array_pkg::FLAG_OVERFLOW])
    else $error("overflow flag not set after wrap");

  a_irq_overflow: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    fl.flags[counter_array_pkg::FLAG_OVERFLOW] && overflow_irq_enable_in |-> irq_out)
    else $error("enabled overflow flag gave no request");

  a_flag_sticky: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    ce_in && fl.flags[counter_array_pkg::FLAG_OVERFLOW] &&
    !wr_mask[counter_array_pkg::POS_OVERFLOW]
    |=> fl.flags[counter_array_pkg::FLAG_OVERFLOW])
    else $error("overflow flag cleared without a write");

  a_run_write: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    ce_in && byte_hit && !sfr_wdata_in[counter_array_pkg::POS_RUN] && !watchdog_enable_in
    ##1 !watchdog_enable_in |-> !counter_run_out)
    else $error("counter still runs after run bit cleared");

  a_unused_zero: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    sfr_rvalid_out |-> !sfr_rdata_out[counter_array_pkg::POS_UNUSED])
    else $error("unused bit read as one");

  a_module_set: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    ce_in && (|module_event_in) |=>
    ((fl.flags[4:0] & $past(module_event_in)) == $past(module_event_in)))
    else $error("module flag not set after event");

  a_irq_module: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    (|(fl.flags[4:0] & module_irq_enable_in)) |-> irq_out)
    else $error("enabled module flag gave no request");

  a_bit_write: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    ce_in && bit_wr_hit && (bit_idx == counter_array_pkg::POS_RUN) && bit_wdata_in
    |=> run ##1 (run || $past(ce_in && (byte_hit || bit_wr_hit))))
    else $error("bit write to run bit lost");

  a_wdt_force: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    ce_in && watchdog_enable_in && bit_wr_hit &&
    (bit_idx == counter_array_pkg::POS_MODULE4) && bit_wdata_in
    |=> watchdog_reset_out)
    else $error("watchdog reset not forced");

  a_wdt_run: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    ce_in && watchdog_enable_in && byte_hit && !sfr_wdata_in[counter_array_pkg::POS_RUN]
    |=> !run && (counter_run_out || !watchdog_enable_in))
    else $error("run state wrong under watchdog");

  a_ovf_gate: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    irq_out && !overflow_irq_enable_in |-> (|(fl.flags[4:0] & module_irq_enable_in)))
    else $error("disabled overflow raised a request");

  a_set_wins: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    ce_in && overflow_event && wr_mask[counter_array_pkg::POS_OVERFLOW] &&
    !wr_val[counter_array_pkg::POS_OVERFLOW] |=> fl.flags[counter_array_pkg::FLAG_OVERFLOW])
    else $error("clear beat a set");

  c_overflow: cover property (@(posedge core_clk_in) disable iff (rst_in)
    ce_in && overflow_event);
  c_wdt_force: cover property (@(posedge core_clk_in) disable iff (rst_in)
    watchdog_reset_out);
  c_set_clear: cover property (@(posedge core_clk_in) disable iff (rst_in)
    ce_in && (|(fl.hw_set & fl.sw_wr & ~fl.sw_val)));
  c_irq: cover property (@(posedge core_clk_in) disable iff (rst_in)
    irq_out);

endmodule // counter_array_ctrl

`default_nettype wire

/* File: verification/tb.sv */
/*
  Self-checking bench for counter_array_ctrl against a byte model.
  Assumes a 10 MHz core clock and inputs driven at the falling edge.
*/
`timescale 1ns/1ns
`default_nettype none

module tb;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        core_clk_in = 1'b0;
  logic        rst_in      = 1'b1;
  logic        ce_in       = 1'b1;
  logic [7:0]  sfr_addr_in = 8'h00, sfr_wdata_in = 8'h00, bit_addr_in = 8'h00;
  logic        sfr_wr_in = 1'b0, sfr_rd_in = 1'b0, bit_wr_in = 1'b0, bit_rd_in = 1'b0;
  logic        bit_wdata_in = 1'b0, counter_tick_in = 1'b0, ovf_en = 1'b0, watchdog_enable = 1'b0;
  logic [15:0] counter_value_in = 16'h0000;
  logic [4:0]  module_event_in = 5'h00, mod_en = 5'h00;
  logic [7:0]  sfr_rdata_out, model = 8'h00;
  logic        sfr_rvalid_out, bit_rdata_out, bit_rvalid_out;
  logic        counter_run_out, irq_out, watchdog_reset_out;
  int          errors = 0, n_tests = 0;

  always #50 core_clk_in = ~core_clk_in;

  counter_array_ctrl i_dut (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .ce_in(ce_in),
    .sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in),
    .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out),
    .sfr_rvalid_out(sfr_rvalid_out), .bit_addr_in(bit_addr_in), .bit_wr_in(bit_wr_in),
    .bit_rd_in(bit_rd_in), .bit_wdata_in(bit_wdata_in), .bit_rdata_out(bit_rdata_out),
    .bit_rvalid_out(bit_rvalid_out), .counter_value_in(counter_value_in),
    .counter_tick_in(counter_tick_in), .counter_run_out(counter_run_out),
    .module_event_in(module_event_in), .module_irq_enable_in(mod_en),
    .overflow_irq_enable_in(ovf_en), .watchdog_enable_in(watchdog_enable),
    .irq_out(irq_out), .watchdog_reset_out(watchdog_reset_out));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic outs();
    check({7'h0, irq_out}, {7'h0, (model[7] & ovf_en) | (|(model[4:0] & mod_en))});
    check({7'h0, counter_run_out}, {7'h0, model[6] | watchdog_enable});
  endtask

  task automatic bwr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr_in = a;
    sfr_wdata_in = d;
    sfr_wr_in = 1'b1;
    @(negedge core_clk_in);
    sfr_wr_in = 1'b0;
    if (a == counter_array_pkg::CTRL_ADDR) model = {d[7:6], 1'b0, d[4:0]};
    model[4:0] = model[4:0] | module_event_in;
    module_event_in = 5'h00;
    outs();
  endtask

  task automatic brd(input logic [7:0] a);
    logic hit;
    hit = (a == counter_array_pkg::CTRL_ADDR);
    sfr_addr_in = a;
    sfr_rd_in = 1'b1;
    @(negedge core_clk_in);
    sfr_rd_in = 1'b0;
    check({7'h0, sfr_rvalid_out}, {7'h0, hit});
    check(sfr_rdata_out, hit ? model : 8'h00);
  endtask

  task automatic bitwr(input int n, input logic v);
    bit_addr_in = 8'hD8 + n[7:0];
    bit_wdata_in = v;
    bit_wr_in = 1'b1;
    @(negedge core_clk_in);
    bit_wr_in = 1'b0;
    if (n != 5) model[n] = v;
    check({7'h0, watchdog_reset_out}, {7'h0, watchdog_enable & v & (n == 4)});
    outs();
  endtask

  task automatic bitrd(input int n);
    bit_addr_in = 8'hD8 + n[7:0];
    bit_rd_in = 1'b1;
    @(negedge core_clk_in);
    bit_rd_in = 1'b0;
    check({7'h0, bit_rvalid_out}, 8'h01);
    check({7'h0, bit_rdata_out}, {7'h0, model[n]});
  endtask

  task automatic ev(input logic [4:0] m, input logic [15:0] v, input logic t);
    module_event_in = m;
    counter_value_in = v;
    counter_tick_in = t;
    @(negedge core_clk_in);
    if (t && v == counter_array_pkg::COUNT_ALL_ONES && (model[6] | watchdog_enable)) model[7] = 1'b1;
    model[4:0] = model[4:0] | m;
    module_event_in = 5'h00;
    counter_tick_in = 1'b0;
    outs();
  endtask

  task automatic report_and_stop();
    $display("comparisons=%0d mismatches=%0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    #500000;
    errors++;
    report_and_stop();
  end

  initial begin
    void'($urandom(477));
    repeat (2) @(negedge core_clk_in);
    rst_in = 1'b0;
    brd(8'hD8);
    bwr(8'hD8, 8'hFF);
    brd(8'hD8);
    bwr(8'hD9, 8'h00);
    brd(8'hD9);
    bwr(8'hD8, 8'h00);
    brd(8'hD8);
    $display("test byte access done");
    for (int n = 0; n < 8; n++) begin
      bitwr(n, 1'b1);
      bitrd(n);
    end
    bitwr(3, 1'b0);
    bitrd(3);
    bwr(8'hD8, 8'h40);
    $display("test bit access done");
    ev(5'h00, 16'hFFFE, 1'b1);
    ev(5'h00, 16'hFFFF, 1'b0);
    brd(8'hD8);
    ev(5'h00, 16'hFFFF, 1'b1);
    ovf_en = 1'b1;
    @(negedge core_clk_in);
    outs();
    brd(8'hD8);
    for (int n = 0; n < 5; n++) begin
      bwr(8'hD8, 8'h00);
      mod_en = 5'h01 << n;
      ev(5'h1F ^ (5'h01 << n), 16'h0000, 1'b0);
      ev(5'h01 << n, 16'h0000, 1'b0);
      brd(8'hD8);
    end
    module_event_in = 5'h04;
    bwr(8'hD8, 8'h00);
    brd(8'hD8);
    $display("test flags done");
    watchdog_enable = 1'b1;
    bwr(8'hD8, 8'h00);
    brd(8'hD8);
    bitwr(4, 1'b1);
    @(negedge core_clk_in);
    check({7'h0, watchdog_reset_out}, 8'h00);
    bitwr(4, 1'b0);
    ev(5'h00, 16'hFFFF, 1'b1);
    brd(8'hD8);
    watchdog_enable = 1'b0;
    // Frozen clock enable ignores a write
    ce_in = 1'b0;
    sfr_addr_in = 8'hD8;
    sfr_wdata_in = ~model;
    sfr_wr_in = 1'b1;
    @(negedge core_clk_in);
    sfr_wr_in = 1'b0;
    ce_in = 1'b1;
    brd(8'hD8);
    $display("test watchdog done");
    for (int i = 0; i < 40; i++) begin
      ovf_en = 1'($urandom);
      mod_en = 5'($urandom);
      module_event_in = 5'($urandom) & 5'($urandom);
      bwr(8'hD8, 8'($urandom));
      ev(5'($urandom), 16'hFFFC + 16'($urandom % 4), 1'($urandom));
      brd(8'hD8);
    end
    $display("test random done");
    report_and_stop();
  end
endmodule // tb

`default_nettype wire
